// ### design/operand_address_decode.sv
// Addressing-mode byte decoder with an AXI4-Lite register slave
//
// The placing of the registers and the AXI4-Lite interface to the registers were left to the implementer.
`timescale 1ns/1ns
`include "decode_cfg.svh"
// Functional notes
// - Mode 11 makes the r/m field a register selector and no address is formed.
// - Mode 00 uses a zero displacement and takes no displacement bytes, except for the direct case.
// - Mode 01 takes one displacement byte, sign-extended to 16 bits.
// - Mode 10 takes two displacement bytes, the second one being the high half.
// - r/m 000 gives base_reg_b plus source index plus displacement.
// - r/m 001 gives base_reg_b plus destination_index plus displacement.
// - r/m 010 gives frame_base_pointer plus source index plus displacement.
// - r/m 100 gives source index plus displacement and 101 destination_index plus displacement.
// - r/m 110 gives frame_base_pointer plus displacement and 111 base_reg_b plus displacement.
// - Mode 00 with r/m 110 takes a 16-bit displacement used alone as the address.
// - Displacement bytes follow the second instruction byte, ahead of any immediate bytes.
// - A move into the code segment register from register or memory is illegal.
// - The status word holds the flags at bits 11..8 and 7,6,4,2,0, other bits unused.
// - The word-size bit selects 16-bit operands when set and 8-bit when clear.
module operand_address_decode (
  // Clock and reset
  input logic aclk,
  input logic aresetn,
  // AXI4-Lite write
  input logic [7:0] awaddr,
  input logic awvalid,
  output logic awready,
  input logic [31:0] wdata,
  input logic [3:0] wstrb,
  input logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input logic bready,
  // AXI4-Lite read
  input logic [7:0] araddr,
  input logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input logic rready,
  // Instruction byte stream
  input logic [7:0] byte_data,
  input logic byte_valid,
  output logic byte_ready,
  // Register file view
  input decode_pkg::gpr_view_s gpr,
  // Decode result
  output decode_pkg::decode_s result,
  output logic result_valid,
  output decode_pkg::flags_s status_flags
);
  import decode_pkg::*;

  logic awready_q, awready_d, wready_q, wready_d, bvalid_q, bvalid_d;
  logic arready_q, arready_d, rvalid_q, rvalid_d;
  logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;
  logic [31:0] rdata_q, rdata_d, wdata_q, wdata_d;
  logic [7:0] awaddr_q, awaddr_d;
  logic [3:0] wstrb_q, wstrb_d;
  logic aw_held_q, aw_held_d, w_held_q, w_held_d;
  logic enable_q, enable_d;
  flags_s flags_q, flags_d, flags_new;
  logic [15:0] flags_word_q, flags_word_in, lane_mask;
  logic do_write;

  dec_state_e state_q, state_d;
  logic [7:0] opc_q, opc_d, modrm_q, modrm_d;
  logic [15:0] disp_q, disp_d, calc_addr;
  logic [1:0] dlen_q, dlen_d;
  logic byte_ready_q, byte_ready_d, result_valid_q, result_valid_d, take;
  decode_s result_q, result_d;

  assign awready = awready_q;
  assign wready = wready_q;
  assign bvalid = bvalid_q;
  assign bresp = bresp_q;
  assign arready = arready_q;
  assign rvalid = rvalid_q;
  assign rresp = rresp_q;
  assign rdata = rdata_q;
  assign byte_ready = byte_ready_q;
  assign result = result_q;
  assign result_valid = result_valid_q;
  assign status_flags = flags_q;

  function automatic logic [1:0] disp_len(input logic [7:0] m);
    if (m[7:6] == `MODE_DISP8)
      disp_len = 2'd1;
    else if (m[7:6] == `MODE_DISP16 || (m[7:6] == `MODE_NODISP && m[2:0] == `RM_DIRECT))
      disp_len = 2'd2;
    else
      disp_len = 2'd0;
  endfunction : disp_len

  assign lane_mask = {{8{wstrb_q[1]}}, {8{wstrb_q[0]}}};
  assign flags_word_in = (flags_word_q & ~lane_mask) | (wdata_q[15:0] & lane_mask);
  assign do_write = aw_held_q && w_held_q && !bvalid_q;

  flags_word u_flags (
    .flags(flags_q),
    .word_out(flags_word_q),
    .word_in(flags_word_in),
    .flags_out(flags_new)
  );

  operand_addr_calc u_calc (
    .mode(modrm_q[7:6]),
    .rm(modrm_q[2:0]),
    .disp(disp_q),
    .gpr(gpr),
    .operand_address(calc_addr)
  );

  // Register slave
  always_comb
  begin
    aw_held_d = aw_held_q;
    w_held_d = w_held_q;
    awaddr_d = awaddr_q;
    wdata_d = wdata_q;
    wstrb_d = wstrb_q;
    bvalid_d = bvalid_q;
    bresp_d = bresp_q;
    arready_d = arready_q;
    rvalid_d = rvalid_q;
    rresp_d = rresp_q;
    rdata_d = rdata_q;
    enable_d = enable_q;
    flags_d = flags_q;
    if (awvalid && awready_q)
    begin
      aw_held_d = 1'b1;
      awaddr_d = awaddr;
    end
    if (wvalid && wready_q)
    begin
      w_held_d = 1'b1;
      wdata_d = wdata;
      wstrb_d = wstrb;
    end
    if (do_write)
    begin
      aw_held_d = 1'b0;
      w_held_d = 1'b0;
      bvalid_d = 1'b1;
      bresp_d = `RESP_OKAY;
      case (awaddr_q)
        `OFS_CTRL:
        begin
          if (wstrb_q[0])
            enable_d = wdata_q[0];
        end
        `OFS_FLAGS: flags_d = flags_new;
        `OFS_STATUS, `OFS_ADDR: ;
        default: bresp_d = `RESP_SLVERR;
      endcase
    end
    if (bvalid_q && bready)
      bvalid_d = 1'b0;
    awready_d = !aw_held_d && !bvalid_d;
    wready_d = !w_held_d && !bvalid_d;
    if (arvalid && arready_q)
    begin
      arready_d = 1'b0;
      rvalid_d = 1'b1;
      rresp_d = `RESP_OKAY;
      case (araddr)
        `OFS_CTRL: rdata_d = {31'h0, enable_q};
        `OFS_STATUS: rdata_d = {(state_q != st_opc), 7'h00, result_q.opcode, result_q.modrm,
                                3'h0, result_q.disp_bytes, result_q.word, result_q.is_reg, result_q.illegal};
        `OFS_ADDR: rdata_d = {16'h0000, result_q.operand_address};
        `OFS_FLAGS: rdata_d = {16'h0000, flags_word_q};
        default:
        begin
          rdata_d = 32'h0000_0000;
          rresp_d = `RESP_SLVERR;
        end
      endcase
    end
    if (rvalid_q && rready)
    begin
      rvalid_d = 1'b0;
      arready_d = 1'b1;
    end
  end

  // Byte stream decoder
  always_comb
  begin
    take = byte_valid && byte_ready_q;
    state_d = state_q;
    opc_d = opc_q;
    modrm_d = modrm_q;
    disp_d = disp_q;
    dlen_d = dlen_q;
    result_d = result_q;
    result_valid_d = 1'b0;
    unique case (state_q)
      st_opc:
      begin
        if (take)
        begin
          opc_d = byte_data;
          state_d = st_modrm;
        end
      end
      st_modrm:
      begin
        if (take)
        begin
          modrm_d = byte_data;
          dlen_d = disp_len(byte_data);
          disp_d = 16'h0000;
          state_d = (disp_len(byte_data) == 2'd0) ? st_calc : st_dlo;
        end
      end
      st_dlo:
      begin
        if (take)
        begin
          disp_d = {{8{byte_data[7]}}, byte_data};
          state_d = (dlen_q == 2'd2) ? st_dhi : st_calc;
        end
      end
      st_dhi:
      begin
        if (take)
        begin
          disp_d[15:8] = byte_data;
          state_d = st_calc;
        end
      end
      st_calc:
      begin
        result_d.opcode = opc_q;
        result_d.modrm = modrm_q;
        result_d.disp = disp_q;
        result_d.disp_bytes = dlen_q;
        result_d.is_reg = (modrm_q[7:6] == `MODE_REG);
        result_d.operand_address = result_d.is_reg ? 16'h0000 : calc_addr;
        result_d.rm_sel = result_d.is_reg ? (8'h01 << modrm_q[2:0]) : 8'h00;
        result_d.word = opc_q[0];
        result_d.illegal = (opc_q == `OPC_MOVE_TO_SEG) && (modrm_q[4:3] == `SEG_CODE_CODE);
        result_d.reg_sel = 8'h01 << modrm_q[5:3];
        result_d.seg_sel = 4'h1 << modrm_q[4:3];
        result_valid_d = 1'b1;
        state_d = st_opc;
      end
      default: state_d = st_opc;
    endcase
    byte_ready_d = enable_q && (state_d != st_calc);
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      awready_q <= 1'b1;
      wready_q <= 1'b1;
      bvalid_q <= 1'b0;
      bresp_q <= `RESP_OKAY;
      arready_q <= 1'b1;
      rvalid_q <= 1'b0;
      rresp_q <= `RESP_OKAY;
      rdata_q <= 32'h0000_0000;
      awaddr_q <= 8'h00;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
      aw_held_q <= 1'b0;
      w_held_q <= 1'b0;
      enable_q <= `CTRL_RESET;
      flags_q <= '0;
      state_q <= st_opc;
      opc_q <= 8'h00;
      modrm_q <= 8'h00;
      disp_q <= 16'h0000;
      dlen_q <= 2'd0;
      byte_ready_q <= 1'b0;
      result_q <= '0;
      result_valid_q <= 1'b0;
    end
    else
    begin
      awready_q <= awready_d;
      wready_q <= wready_d;
      bvalid_q <= bvalid_d;
      bresp_q <= bresp_d;
      arready_q <= arready_d;
      rvalid_q <= rvalid_d;
      rresp_q <= rresp_d;
      rdata_q <= rdata_d;
      awaddr_q <= awaddr_d;
      wdata_q <= wdata_d;
      wstrb_q <= wstrb_d;
      aw_held_q <= aw_held_d;
      w_held_q <= w_held_d;
      enable_q <= enable_d;
      flags_q <= flags_d;
      state_q <= state_d;
      opc_q <= opc_d;
      modrm_q <= modrm_d;
      disp_q <= disp_d;
      dlen_q <= dlen_d;
      byte_ready_q <= byte_ready_d;
      result_q <= result_d;
      result_valid_q <= result_valid_d;
    end
  end

  // Checks
  gpr_view_s gpr_seen_q;
  logic mem_v;
  always_ff @(posedge aclk)
    gpr_seen_q <= gpr;
  assign mem_v = result_valid_q && !result_q.is_reg;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_reg_mode_noaddr: assert property (result_valid_q && result_q.modrm[7:6] == 2'b11 |->
    result_q.is_reg && result_q.operand_address == 16'h0000 && result_q.disp_bytes == 2'd0)
    else $error("register mode formed an address");
  a_mod0_nodisp: assert property (result_valid_q && result_q.modrm[7:6] == 2'b00 &&
    result_q.modrm[2:0] != 3'b110 |-> result_q.disp_bytes == 2'd0 && result_q.disp == 16'h0000)
    else $error("mode 00 took a displacement");
  a_disp8_sext: assert property (result_valid_q && result_q.modrm[7:6] == 2'b01 |->
    result_q.disp_bytes == 2'd1 && result_q.disp[15:8] == {8{result_q.disp[7]}})
    else $error("byte displacement not sign-extended");
  a_disp16_high: assert property (state_q == st_dhi && take |->
    ##2 result_valid_q && result_q.disp[15:8] == $past(byte_data, 2))
    else $error("second displacement byte not high half");
  a_bx_si_sum: assert property (mem_v && result_q.modrm[2:0] == 3'b000 |->
    result_q.operand_address == gpr_seen_q.base_reg_b + gpr_seen_q.source_index + result_q.disp)
    else $error("address 000 wrong");
  a_bx_di_sum: assert property (mem_v && result_q.modrm[2:0] == 3'b001 |->
    result_q.operand_address == gpr_seen_q.base_reg_b + gpr_seen_q.destination_index + result_q.disp)
    else $error("address 001 wrong");
  a_bp_si_sum: assert property (mem_v && result_q.modrm[2:0] == 3'b010 |->
    result_q.operand_address == gpr_seen_q.frame_base_pointer + gpr_seen_q.source_index + result_q.disp)
    else $error("address 010 wrong");
  a_bp_di_sum: assert property (mem_v && result_q.modrm[2:0] == 3'b011 |->
    result_q.operand_address == gpr_seen_q.frame_base_pointer + gpr_seen_q.destination_index + result_q.disp)
    else $error("address 011 wrong");
  a_index_only: assert property (mem_v && result_q.modrm[2:1] == 2'b10 |->
    result_q.operand_address == (result_q.modrm[0] ? gpr_seen_q.destination_index : gpr_seen_q.source_index)
    + result_q.disp)
    else $error("index-only address wrong");
  a_single_base: assert property (mem_v && result_q.modrm[2:1] == 2'b11 &&
    !(result_q.modrm[7:6] == 2'b00 && !result_q.modrm[0]) |-> result_q.operand_address ==
    (result_q.modrm[0] ? gpr_seen_q.base_reg_b : gpr_seen_q.frame_base_pointer) + result_q.disp)
    else $error("single-base address wrong");
  a_direct_addr: assert property (result_valid_q && result_q.modrm[7:6] == 2'b00 &&
    result_q.modrm[2:0] == 3'b110 |-> result_q.disp_bytes == 2'd2 && result_q.operand_address == result_q.disp)
    else $error("direct address wrong");
  a_disp_after_modrm: assert property (state_q == st_dlo && !$stable(state_q) |->
    $past(state_q) == st_modrm)
    else $error("displacement before second byte");
  a_code_seg_move: assert property (result_valid_q |-> result_q.illegal ==
    (result_q.opcode == 8'h8e && result_q.modrm[4:3] == 2'b01))
    else $error("code segment move flag wrong");
  a_flags_layout: assert property (do_write && awaddr_q == 8'h0c && wstrb_q == 4'hf |->
    ##1 flags_word_q == ($past(wdata_q[15:0]) & 16'h0fd5))
    else $error("status word layout wrong");
  a_word_size: assert property (result_valid_q |-> result_q.word == result_q.opcode[0])
    else $error("word size bit not followed");
  a_reg_select: assert property (result_valid_q |-> result_q.reg_sel == (8'h01 << result_q.modrm[5:3]) &&
    (result_q.modrm[4:3] != 2'b11 || result_q.seg_sel == 4'h8))
    else $error("register select wrong");
endmodule : operand_address_decode

// ### include/decode_cfg.svh
// Offsets, flag bit positions, reset values and codes for the operand address decoder
`ifndef DECODE_CFG_SVH
`define DECODE_CFG_SVH
`define OFS_CTRL 8'h00
`define OFS_STATUS 8'h04
`define OFS_ADDR 8'h08
`define OFS_FLAGS 8'h0c
`define CTRL_RESET 1'b1
`define FLAGS_RESET 16'h0000
`define FLAGS_MASK 16'h0fd5
`define FBIT_CARRY 0
`define FBIT_PARITY 2
`define FBIT_AUX 4
`define FBIT_ZERO 6
`define FBIT_SIGN 7
`define FBIT_TRAP 8
`define FBIT_INTEN 9
`define FBIT_DIR 10
`define FBIT_OVER 11
`define MODE_NODISP 2'b00
`define MODE_DISP8 2'b01
`define MODE_DISP16 2'b10
`define MODE_REG 2'b11
`define RM_DIRECT 3'b110
`define OPC_MOVE_TO_SEG 8'h8e
`define SEG_CODE_CODE 2'b01
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10
`endif

// ### include/decode_pkg.sv
// Types shared by the operand address decoder
package decode_pkg;
  typedef enum logic [2:0] {
    st_opc = 3'b000,
    st_modrm = 3'b001,
    st_dlo = 3'b010,
    st_dhi = 3'b011,
    st_calc = 3'b100
  } dec_state_e;

  typedef struct packed {
    logic [15:0] base_reg_b;
    logic [15:0] frame_base_pointer;
    logic [15:0] source_index;
    logic [15:0] destination_index;
  } gpr_view_s;

  typedef struct packed {
    logic overflow_flag;
    logic direction_flag;
    logic int_enable_flag;
    logic trap_flag;
    logic sign_flag;
    logic zero_flag;
    logic aux_carry_flag;
    logic parity_flag;
    logic carry_flag;
  } flags_s;

  typedef struct packed {
    logic [7:0] opcode;
    logic [7:0] modrm;
    logic [15:0] disp;
    logic [1:0] disp_bytes;
    logic [15:0] operand_address;
    logic is_reg;
    logic word;
    logic illegal;
    logic [7:0] reg_sel;
    logic [7:0] rm_sel;
    logic [3:0] seg_sel;
  } decode_s;
endpackage : decode_pkg

// ### design/operand_addr_calc.sv
// Operand address adder selected by the register-or-memory field
`timescale 1ns/1ns
`include "decode_cfg.svh"
module operand_addr_calc (
  // Addressing fields
  input logic [1:0] mode,
  input logic [2:0] rm,
  input logic [15:0] disp,
  // Register view
  input decode_pkg::gpr_view_s gpr,
  // Result
  output logic [15:0] operand_address
);
  import decode_pkg::*;

  always_comb
  begin
    unique case (rm)
      3'b000: operand_address = gpr.base_reg_b + gpr.source_index + disp;
      3'b001: operand_address = gpr.base_reg_b + gpr.destination_index + disp;
      3'b010: operand_address = gpr.frame_base_pointer + gpr.source_index + disp;
      3'b011: operand_address = gpr.frame_base_pointer + gpr.destination_index + disp;
      3'b100: operand_address = gpr.source_index + disp;
      3'b101: operand_address = gpr.destination_index + disp;
      3'b110: operand_address = (mode == `MODE_NODISP) ? disp : gpr.frame_base_pointer + disp;
      3'b111: operand_address = gpr.base_reg_b + disp;
    endcase
  end
endmodule : operand_addr_calc

// ### design/flags_word.sv
// Packs and unpacks the 16-bit status word
`timescale 1ns/1ns
`include "decode_cfg.svh"
module flags_word (
  // Flags to pack
  input decode_pkg::flags_s flags,
  output logic [15:0] word_out,
  // Word to unpack
  input logic [15:0] word_in,
  output decode_pkg::flags_s flags_out
);
  import decode_pkg::*;

  always_comb
  begin
    word_out = 16'h0000;
    word_out[`FBIT_OVER] = flags.overflow_flag;
    word_out[`FBIT_DIR] = flags.direction_flag;
    word_out[`FBIT_INTEN] = flags.int_enable_flag;
    word_out[`FBIT_TRAP] = flags.trap_flag;
    word_out[`FBIT_SIGN] = flags.sign_flag;
    word_out[`FBIT_ZERO] = flags.zero_flag;
    word_out[`FBIT_AUX] = flags.aux_carry_flag;
    word_out[`FBIT_PARITY] = flags.parity_flag;
    word_out[`FBIT_CARRY] = flags.carry_flag;
    flags_out.overflow_flag = word_in[`FBIT_OVER];
    flags_out.direction_flag = word_in[`FBIT_DIR];
    flags_out.int_enable_flag = word_in[`FBIT_INTEN];
    flags_out.trap_flag = word_in[`FBIT_TRAP];
    flags_out.sign_flag = word_in[`FBIT_SIGN];
    flags_out.zero_flag = word_in[`FBIT_ZERO];
    flags_out.aux_carry_flag = word_in[`FBIT_AUX];
    flags_out.parity_flag = word_in[`FBIT_PARITY];
    flags_out.carry_flag = word_in[`FBIT_CARRY];
  end
endmodule : flags_word

// ### testbench/test_operand_address_decode.sv
// Self-checking bench for the operand address decoder
`timescale 1ns/1ns
`include "decode_cfg.svh"
module test_operand_address_decode;
  import decode_pkg::*;
  logic aclk;
  logic aresetn;
  logic [7:0] awaddr, araddr, byte_data;
  logic awvalid, wvalid, bready, arvalid, rready, byte_valid;
  logic awready, wready, bvalid, arready, rvalid, byte_ready, result_valid;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp;
  gpr_view_s gpr;
  decode_s result;
  flags_s status_flags;
  int err_count = 0;
  int n_tests = 0;
  int cycles = 0;

  operand_address_decode dut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
    .rresp(rresp), .rvalid(rvalid), .rready(rready), .byte_data(byte_data), .byte_valid(byte_valid),
    .byte_ready(byte_ready), .gpr(gpr), .result(result), .result_valid(result_valid),
    .status_flags(status_flags));

  initial
  begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end

  task results;
    $display("Checks %0d, mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0)
    begin
      $display("== PASSED ==");
    end
    else
    begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : results

  always @(posedge aclk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      err_count++;
      $display("Error at %0t: timeout after %h cycles, limit %h", $time, cycles, 20000);
      results();
    end
  end

  task check(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      err_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  task axi_write(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s, input logic [1:0] er);
    logic aw_t, w_t, a_r, w_r;
    logic [1:0] resp;
    aw_t = 1'b0;
    w_t = 1'b0;
    @(posedge aclk);
    awaddr <= a;
    awvalid <= 1'b1;
    wdata <= d;
    wstrb <= s;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(aw_t && w_t))
    begin
      @(negedge aclk);
      a_r = awready;
      w_r = wready;
      @(posedge aclk);
      if (a_r === 1'b1 && !aw_t)
      begin
        awvalid <= 1'b0;
        aw_t = 1'b1;
      end
      if (w_r === 1'b1 && !w_t)
      begin
        wvalid <= 1'b0;
        w_t = 1'b1;
      end
    end
    do @(negedge aclk); while (bvalid !== 1'b1);
    resp = bresp;
    @(posedge aclk);
    bready <= 1'b0;
    check({30'h0, resp}, {30'h0, er});
  endtask : axi_write

  task axi_read(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    logic [31:0] d;
    logic [1:0] resp;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(negedge aclk); while (arready !== 1'b1);
    @(posedge aclk);
    arvalid <= 1'b0;
    do @(negedge aclk); while (rvalid !== 1'b1);
    d = rdata;
    resp = rresp;
    @(posedge aclk);
    rready <= 1'b0;
    check({30'h0, resp}, {30'h0, er});
    check(d, ed);
  endtask : axi_read

  task send_byte(input logic [7:0] b);
    byte_data <= b;
    byte_valid <= 1'b1;
    do @(negedge aclk); while (byte_ready !== 1'b1);
    @(posedge aclk);
  endtask : send_byte

  // Own model of the address table, wrapping at 16 bits
  task decode(input logic [7:0] opc, input logic [7:0] mrm, input logic [15:0] d, input int nb);
    logic [15:0] dx, exp_addr;
    logic rg;
    rg = (mrm[7:6] == 2'b11);
    dx = (nb == 1) ? {{8{d[7]}}, d[7:0]} : ((nb == 2) ? d : 16'h0000);
    case (mrm[2:0])
      3'h0: exp_addr = gpr.base_reg_b + gpr.source_index + dx;
      3'h1: exp_addr = gpr.base_reg_b + gpr.destination_index + dx;
      3'h2: exp_addr = gpr.frame_base_pointer + gpr.source_index + dx;
      3'h3: exp_addr = gpr.frame_base_pointer + gpr.destination_index + dx;
      3'h4: exp_addr = gpr.source_index + dx;
      3'h5: exp_addr = gpr.destination_index + dx;
      3'h6: exp_addr = (mrm[7:6] == 2'b00) ? dx : gpr.frame_base_pointer + dx;
      default: exp_addr = gpr.base_reg_b + dx;
    endcase
    if (rg)
      exp_addr = 16'h0000;
    @(posedge aclk);
    send_byte(opc);
    send_byte(mrm);
    if (nb > 0)
      send_byte(d[7:0]);
    if (nb > 1)
      send_byte(d[15:8]);
    byte_valid <= 1'b0;
    do @(negedge aclk); while (result_valid !== 1'b1);
    check({16'h0, result.operand_address}, {16'h0, exp_addr});
    check({16'h0, result.disp}, {16'h0, dx});
    check({30'h0, result.disp_bytes}, nb[31:0]);
    check({24'h0, result.opcode}, {24'h0, opc});
    check({24'h0, result.modrm}, {24'h0, mrm});
    check({29'h0, result.is_reg, result.word, result.illegal},
      {29'h0, rg, opc[0], (opc == `OPC_MOVE_TO_SEG && mrm[4:3] == `SEG_CODE_CODE)});
    check({24'h0, result.reg_sel}, 32'h1 << mrm[5:3]);
    check({24'h0, result.rm_sel}, rg ? (32'h1 << mrm[2:0]) : 32'h0);
    check({28'h0, result.seg_sel}, 32'h1 << mrm[4:3]);
    @(negedge aclk);
    check({31'h0, result_valid}, 32'h0);
  endtask : decode

  function automatic flags_s flags_of(input logic [15:0] w);
    return {w[11], w[10], w[9], w[8], w[7], w[6], w[4], w[2], w[0]};
  endfunction : flags_of

  initial
  begin
    aresetn = 1'b0;
    {awaddr, araddr, byte_data, wdata, wstrb} = '0;
    {awvalid, wvalid, bready, arvalid, rready, byte_valid} = '0;
    gpr = {16'h1200, 16'hf400, 16'h0056, 16'h0078};
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    axi_read(`OFS_CTRL, 32'h1, `RESP_OKAY);
    axi_read(`OFS_FLAGS, 32'h0, `RESP_OKAY);
    axi_read(`OFS_ADDR, 32'h0, `RESP_OKAY);
    axi_write(`OFS_FLAGS, 32'hffffffff, 4'hf, `RESP_OKAY);
    axi_read(`OFS_FLAGS, 32'h00000fd5, `RESP_OKAY);
    axi_write(`OFS_FLAGS, 32'h00000000, 4'h1, `RESP_OKAY);
    axi_read(`OFS_FLAGS, 32'h00000f00, `RESP_OKAY);
    for (int i = 0; i < 16; i++)
    begin
      axi_write(`OFS_FLAGS, 32'h1 << i, 4'hf, `RESP_OKAY);
      axi_read(`OFS_FLAGS, (32'h1 << i) & 32'h0fd5, `RESP_OKAY);
      check({23'h0, status_flags}, {23'h0, flags_of(16'(32'h1 << i))});
    end
    axi_write(8'h10, 32'h1, 4'hf, `RESP_SLVERR);
    axi_read(8'h10, 32'h0, `RESP_SLVERR);
    axi_write(`OFS_ADDR, 32'h5555, 4'hf, `RESP_OKAY);
    axi_read(`OFS_ADDR, 32'h0, `RESP_OKAY);
    $display("Test registers done");
    for (int r = 0; r < 8; r++)
      decode(8'h8b, {2'b10, 3'(r), 3'(r)}, 16'hf234, 2);
    decode(8'h8a, 8'b01_011_111, 16'h0080, 1);
    decode(8'h8b, 8'b01_000_010, 16'h007f, 1);
    decode(8'h8b, 8'b00_001_000, 16'h0000, 0);
    decode(8'h8b, 8'b00_010_110, 16'hbeef, 2);
    axi_read(`OFS_ADDR, 32'h0000beef, `RESP_OKAY);
    for (int r = 0; r < 8; r++)
      decode(8'h89, {2'b11, 3'(7 - r), 3'(r)}, 16'h0000, 0);
    decode(8'h8e, 8'b00_001_011, 16'h0000, 0);
    decode(8'h8e, 8'b00_011_011, 16'h0000, 0);
    $display("Test decode done");
    axi_write(`OFS_CTRL, 32'h0, 4'h1, `RESP_OKAY);
    repeat (3) @(posedge aclk);
    @(negedge aclk);
    check({31'h0, byte_ready}, 32'h0);
    axi_write(`OFS_CTRL, 32'h1, 4'h1, `RESP_OKAY);
    decode(8'h8b, 8'b10_100_100, 16'h8001, 2);
    $display("Test enable done");
    results();
  end
endmodule : test_operand_address_decode
